// ==== logic/mit_pkg.sv ====
//==========================================================
// Purpose: Shared constants and opcode set of the executor
// Assumes: One 100 MHz clock, synchronous active-high reset
// Notes:   Opcode codes are internal to the core decode
package mit_pkg;

  // Opcodes of the executor
  typedef enum logic [5:0] {
    OP_IDLE, OP_ROT_R, OP_ROT_R_W, OP_ROT_RC, OP_ROT_RC_W,
    OP_ROT_L, OP_ROT_L_W, OP_ROT_LC, OP_ROT_LC_W,
    OP_COPY_M2W, OP_COPY_W2M, OP_COPY_I2W,
    OP_BIT_CLR, OP_BIT_SET,
    OP_JUMP, OP_CALL, OP_SUB_EXIT, OP_SUB_EXIT_IMM, OP_INT_EXIT,
    OP_SKIP_ZERO, OP_SKIP_ZERO_W, OP_SKIP_BIT_CLR, OP_SKIP_BIT_SET,
    OP_INC_SKIP, OP_DEC_SKIP, OP_INC_SKIP_W, OP_DEC_SKIP_W,
    OP_TBL_CUR, OP_TBL_LAST,
    OP_BYTE_CLR, OP_BYTE_SET, OP_WDT_CLR, OP_WDT_PRE1, OP_WDT_PRE2,
    OP_SWAP, OP_SWAP_W, OP_HALT
  } mit_op_t;

  typedef enum logic [1:0] {PRE_NONE, PRE_FIRST, PRE_SECOND} mit_pre_t;

  // Register port map
  localparam logic [3:0]  REG_STATUS     = 4'h0;
  localparam logic [3:0]  REG_CTRL       = 4'h1;
  localparam logic [3:0]  REG_WORK       = 4'h2;
  // Status fields
  localparam int          ST_CARRY_BIT   = 0;
  localparam int          ST_EXPIRY_BIT  = 1;
  localparam int          ST_HALTF_BIT   = 2;
  localparam int          ST_PDOWN_BIT   = 3;
  // Control fields
  localparam int          CT_WAKE_BIT    = 0;
  localparam int          CT_CARRY_BIT   = 1;
  localparam int          CT_CLOAD_BIT   = 2;

  // Data memory address of the program counter low byte
  localparam logic [7:0]  PC_LOW_ADDR    = 8'h06;
  localparam logic [3:0]  LAST_PAGE      = 4'hf;

  // Reset values
  localparam logic [7:0]  WORK_RST       = 8'h00;
  localparam logic        CARRY_RST      = 1'b0;
  localparam logic        EXPIRY_RST     = 1'b0;
  localparam logic        HALTF_RST      = 1'b0;
  localparam logic [6:0]  TABLE_HIGH_RST = 7'h00;

  // Instruction lengths in machine cycles
  localparam int          CYC_SHORT      = 1;
  localparam int          CYC_LONG       = 2;

endpackage : mit_pkg

// ==== logic/mit_exec.sv ====
//==========================================================
// Purpose: Executes rotate, move, bit, branch, skip, table and misc ops
// Assumes: Operand byte of [m] and the ROM word arrive from the core
// Notes:   Two-cycle ops hold ready low for one extra cycle
module mit_exec
  import mit_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        instr_valid,
  input  wire logic [5:0]  instr_op,
  input  wire logic [7:0]  instr_addr,
  input  wire logic [2:0]  instr_bit,
  input  wire logic [7:0]  instr_imm,
  input  wire logic [11:0] instr_target,
  input  wire logic [7:0]  mem_operand,
  input  wire logic [11:0] pc_now,
  input  wire logic [11:0] stack_top,
  input  wire logic [7:0]  table_ptr,
  input  wire logic [14:0] pm_rdata,
  input  wire logic        wdt_timeout,
  input  wire logic [3:0]  reg_addr,
  input  wire logic [7:0]  reg_wdata,
  input  wire logic        reg_we,
  input  wire logic        reg_re,
  output logic             ready_reg,
  output logic             retire_reg,
  output logic [7:0]       work_reg,
  output logic             carry_reg,
  output logic             expiry_flag_reg,
  output logic             halt_flag_reg,
  output logic             power_down_reg,
  output logic             dm_we_reg,
  output logic [7:0]       dm_waddr_reg,
  output logic [7:0]       dm_wdata_reg,
  output logic             pc_load_reg,
  output logic [11:0]      pc_value_reg,
  output logic             stack_push_reg,
  output logic [11:0]      stack_data_reg,
  output logic             stack_pop_reg,
  output logic             skip_next_reg,
  output logic             pm_req_reg,
  output logic [11:0]      pm_addr_reg,
  output logic [6:0]       table_high_reg,
  output logic             wdt_clear_reg,
  output logic [7:0]       reg_rdata_reg
);

  //==========================================================
  // Decode and compute
  typedef enum {ST_RUN, ST_EXTRA, ST_TABLE} mit_state_t;
  mit_state_t  state_reg;
  mit_pre_t    pre_reg;
  mit_op_t     op;
  logic        issue;
  logic [7:0]  res;
  logic [7:0]  mask;
  logic        wr_mem, wr_work, c_upd, c_new, skip, long_op;
  logic        do_wclr, do_halt, pc_jump, push, pop, tbl;
  logic [11:0] jump_to;
  logic        wake;

  assign op    = mit_op_t'(instr_op);
  assign issue = instr_valid && ready_reg;
  assign mask  = 8'h01 << instr_bit;
  assign wake  = reg_we && reg_addr == REG_CTRL && reg_wdata[CT_WAKE_BIT];

  always_comb begin
    res = mem_operand;
    wr_mem = 1'b0;
    wr_work = 1'b0;
    c_upd = 1'b0;
    c_new = carry_reg;
    skip = 1'b0;
    long_op = 1'b0;
    do_wclr = 1'b0;
    do_halt = 1'b0;
    pc_jump = 1'b0;
    push = 1'b0;
    pop = 1'b0;
    tbl = 1'b0;
    jump_to = instr_target;
    unique case (op)
      OP_ROT_R, OP_ROT_R_W: begin
        res = {mem_operand[0], mem_operand[7:1]};
        wr_mem = (op == OP_ROT_R);
        wr_work = (op == OP_ROT_R_W);
      end
      OP_ROT_L, OP_ROT_L_W: begin
        res = {mem_operand[6:0], mem_operand[7]};
        wr_mem = (op == OP_ROT_L);
        wr_work = (op == OP_ROT_L_W);
      end
      OP_ROT_RC, OP_ROT_RC_W: begin
        res = {carry_reg, mem_operand[7:1]};
        c_upd = 1'b1;
        c_new = mem_operand[0];
        wr_mem = (op == OP_ROT_RC);
        wr_work = (op == OP_ROT_RC_W);
      end
      OP_ROT_LC, OP_ROT_LC_W: begin
        res = {mem_operand[6:0], carry_reg};
        c_upd = 1'b1;
        c_new = mem_operand[7];
        wr_mem = (op == OP_ROT_LC);
        wr_work = (op == OP_ROT_LC_W);
      end
      OP_COPY_M2W: wr_work = 1'b1;
      OP_COPY_W2M: begin
        res = work_reg;
        wr_mem = 1'b1;
      end
      OP_COPY_I2W: begin
        res = instr_imm;
        wr_work = 1'b1;
      end
      OP_BIT_CLR: begin
        res = mem_operand & ~mask;
        wr_mem = 1'b1;
      end
      OP_BIT_SET: begin
        res = mem_operand | mask;
        wr_mem = 1'b1;
      end
      OP_JUMP: pc_jump = 1'b1;
      OP_CALL: begin
        pc_jump = 1'b1;
        push = 1'b1;
      end
      OP_SUB_EXIT, OP_INT_EXIT: begin
        pc_jump = 1'b1;
        pop = 1'b1;
        jump_to = stack_top;
      end
      OP_SUB_EXIT_IMM: begin
        pc_jump = 1'b1;
        pop = 1'b1;
        jump_to = stack_top;
        res = instr_imm;
        wr_work = 1'b1;
      end
      OP_SKIP_ZERO: skip = (mem_operand == 8'h00);
      OP_SKIP_ZERO_W: begin
        wr_work = 1'b1;
        skip = (mem_operand == 8'h00);
      end
      OP_SKIP_BIT_CLR: skip = !mem_operand[instr_bit];
      OP_SKIP_BIT_SET: skip = mem_operand[instr_bit];
      OP_INC_SKIP, OP_INC_SKIP_W, OP_DEC_SKIP, OP_DEC_SKIP_W: begin
        res = (op == OP_INC_SKIP || op == OP_INC_SKIP_W) ? mem_operand + 8'h01
                                                          : mem_operand - 8'h01;
        skip = (res == 8'h00);
        wr_mem = (op == OP_INC_SKIP || op == OP_DEC_SKIP);
        wr_work = !wr_mem;
      end
      OP_TBL_CUR, OP_TBL_LAST: tbl = 1'b1;
      OP_BYTE_CLR: begin
        res = 8'h00;
        wr_mem = 1'b1;
      end
      OP_BYTE_SET: begin
        res = 8'hff;
        wr_mem = 1'b1;
      end
      OP_WDT_CLR: do_wclr = 1'b1;
      OP_WDT_PRE1: do_wclr = (pre_reg == PRE_SECOND);
      OP_WDT_PRE2: do_wclr = (pre_reg == PRE_FIRST);
      OP_SWAP, OP_SWAP_W: begin
        res = {mem_operand[3:0], mem_operand[7:4]};
        wr_mem = (op == OP_SWAP);
        wr_work = (op == OP_SWAP_W);
      end
      OP_HALT: do_halt = 1'b1;
      OP_IDLE: ;
      default: ;  // Unused codes act as idle
    endcase
    // Writing the low byte reloads the program counter
    if (wr_mem && instr_addr == PC_LOW_ADDR) begin
      pc_jump = 1'b1;
      jump_to = {pc_now[11:8], res};
    end
    long_op = pc_jump || skip;
  end

  //==========================================================
  // Sequencing
  always_ff @(posedge clk) begin
    if (rst) begin
      state_reg <= ST_RUN;
      ready_reg <= 1'b0;
      retire_reg <= 1'b0;
    end else begin
      retire_reg <= 1'b0;
      unique case (state_reg)
        ST_RUN: begin
          if (issue && tbl) begin
            state_reg <= ST_TABLE;
            ready_reg <= 1'b0;
          end else if (issue && long_op) begin
            state_reg <= ST_EXTRA;
            ready_reg <= 1'b0;
            retire_reg <= 1'b1;
          end else begin
            ready_reg <= !(issue && do_halt) && !(power_down_reg && !wake);
            retire_reg <= issue;
          end
        end
        ST_EXTRA, ST_TABLE: begin
          state_reg <= ST_RUN;
          ready_reg <= 1'b1;
          retire_reg <= (state_reg == ST_TABLE);
        end
      endcase
    end
  end

  //==========================================================
  // Working register and carry
  always_ff @(posedge clk) begin
    if (rst) begin
      work_reg <= WORK_RST;
      carry_reg <= CARRY_RST;
    end else begin
      if (issue && wr_work) begin
        work_reg <= res;
      end
      if (issue && c_upd) begin
        carry_reg <= c_new;
      end else if (reg_we && reg_addr == REG_CTRL && reg_wdata[CT_CLOAD_BIT]) begin
        carry_reg <= reg_wdata[CT_CARRY_BIT];
      end
    end
  end

  //==========================================================
  // Memory writes, branches and table fetch
  always_ff @(posedge clk) begin
    if (rst) begin
      dm_we_reg <= 1'b0;
      dm_waddr_reg <= 8'h00;
      dm_wdata_reg <= 8'h00;
      pc_load_reg <= 1'b0;
      pc_value_reg <= 12'h000;
      stack_push_reg <= 1'b0;
      stack_data_reg <= 12'h000;
      stack_pop_reg <= 1'b0;
      skip_next_reg <= 1'b0;
      pm_req_reg <= 1'b0;
      pm_addr_reg <= 12'h000;
      table_high_reg <= TABLE_HIGH_RST;
    end else begin
      dm_we_reg <= issue && wr_mem;
      pc_load_reg <= issue && pc_jump;
      stack_push_reg <= issue && push;
      stack_pop_reg <= issue && pop;
      skip_next_reg <= issue && skip;
      pm_req_reg <= issue && tbl;
      if (issue) begin
        dm_waddr_reg <= instr_addr;
        dm_wdata_reg <= res;
        pc_value_reg <= jump_to;
        stack_data_reg <= pc_now + 12'h001;
        pm_addr_reg <= {(op == OP_TBL_LAST) ? LAST_PAGE : pc_now[11:8], table_ptr};
      end
      // Word is read while the request stands
      if (state_reg == ST_TABLE) begin
        table_high_reg <= pm_rdata[14:8];
        dm_we_reg <= 1'b1;
        dm_wdata_reg <= pm_rdata[7:0];
      end
    end
  end

  //==========================================================
  // Watchdog and power-down flags
  always_ff @(posedge clk) begin
    if (rst) begin
      expiry_flag_reg <= EXPIRY_RST;
      halt_flag_reg <= HALTF_RST;
      power_down_reg <= 1'b0;
      wdt_clear_reg <= 1'b0;
      pre_reg <= PRE_NONE;
    end else begin
      wdt_clear_reg <= issue && (do_wclr || do_halt);
      if (issue) begin
        pre_reg <= (op == OP_WDT_PRE1 && !do_wclr) ? PRE_FIRST :
                   (op == OP_WDT_PRE2 && !do_wclr) ? PRE_SECOND : PRE_NONE;
      end
      // Timeout wins over a clear in the same cycle
      if (wdt_timeout) begin
        expiry_flag_reg <= 1'b1;
      end else if (issue && (do_wclr || do_halt)) begin
        expiry_flag_reg <= 1'b0;
      end
      if (issue && do_halt) begin
        halt_flag_reg <= 1'b1;
        power_down_reg <= 1'b1;
      end else begin
        if (issue && do_wclr) halt_flag_reg <= 1'b0;
        if (wake || wdt_timeout) power_down_reg <= 1'b0;
      end
    end
  end

  //==========================================================
  // Register port
  always_ff @(posedge clk) begin
    if (rst) begin
      reg_rdata_reg <= 8'h00;
    end else if (reg_re) begin
      unique case (reg_addr)
        REG_STATUS: reg_rdata_reg <= {4'h0, power_down_reg, halt_flag_reg, expiry_flag_reg, carry_reg};
        REG_WORK:   reg_rdata_reg <= work_reg;
        default:    reg_rdata_reg <= 8'h00;
      endcase
    end else begin
      reg_rdata_reg <= 8'h00;
    end
  end

  //==========================================================
  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  rot_flags_a: assert property (issue && op inside {OP_ROT_R, OP_ROT_R_W, OP_ROT_L, OP_ROT_L_W}
    && instr_addr != PC_LOW_ADDR && !wdt_timeout && !reg_we
    |=> $stable(carry_reg) && $stable(expiry_flag_reg) && ready_reg) else $error("plain rotate changed a flag");
  rot_carry_a: assert property (issue && op == OP_ROT_RC_W
    |=> carry_reg == $past(mem_operand[0]) && work_reg == {$past(carry_reg), $past(mem_operand[7:1])})
    else $error("rotate through carry wrong");
  bit_only_a: assert property (issue && op == OP_BIT_SET && instr_addr != PC_LOW_ADDR
    |=> dm_we_reg && dm_wdata_reg == ($past(mem_operand) | (8'h01 << $past(instr_bit))))
    else $error("bit set wrote wrong byte");
  branch_two_a: assert property (issue && op == OP_JUMP
    |=> pc_load_reg && !ready_reg ##1 ready_reg) else $error("jump not two cycles");
  skip_len_a: assert property (issue && skip && !tbl
    |=> skip_next_reg && !ready_reg) else $error("taken skip not two cycles");
  low_write_a: assert property (issue && wr_mem && instr_addr == PC_LOW_ADDR
    |=> pc_load_reg && !ready_reg && pc_value_reg[7:0] == dm_wdata_reg) else $error("low byte write not two cycles");
  table_seq_a: assert property (issue && tbl
    |=> pm_req_reg && !ready_reg ##1 dm_we_reg && ready_reg) else $error("table read sequence wrong");
  pair_lone_a: assert property (issue && op == OP_WDT_PRE2 && pre_reg != PRE_FIRST
    |=> !wdt_clear_reg) else $error("lone pre-clear cleared watchdog");
  pair_clear_a: assert property (issue && op == OP_WDT_PRE1 && pre_reg != PRE_SECOND
    ##1 issue && op == OP_WDT_PRE2 && !wdt_timeout
    |=> wdt_clear_reg && !expiry_flag_reg && !halt_flag_reg) else $error("pre-clear pair ignored");
  halt_entry_a: assert property (issue && op == OP_HALT
    |=> power_down_reg && halt_flag_reg && !ready_reg) else $error("halt not entered");

  cov_skip_c:  cover property (issue && skip);
  cov_table_c: cover property (issue && op == OP_TBL_LAST ##2 ready_reg);
  cov_pair_c:  cover property (issue && op == OP_WDT_PRE1 ##1 issue && op == OP_WDT_PRE2);

endmodule : mit_exec

// ==== tb/mit_mem_model.sv ====
//==========================================================
// Purpose: Data memory, stack and program memory beside the executor
// Assumes: Writes land on the clock edge that ends the strobe cycle
// Notes:   Program words are a fixed function of their address
module mit_mem_model (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic [7:0]  instr_addr,
  input  wire logic        dm_we_reg,
  input  wire logic [7:0]  dm_waddr_reg,
  input  wire logic [7:0]  dm_wdata_reg,
  input  wire logic        stack_push_reg,
  input  wire logic [11:0] stack_data_reg,
  input  wire logic        stack_pop_reg,
  input  wire logic        pm_req_reg,
  input  wire logic [11:0] pm_addr_reg,
  output logic      [7:0]  mem_operand,
  output logic      [11:0] stack_top,
  output logic      [14:0] pm_rdata
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0]  dm [256];
  logic [11:0] stk [8];
  logic [2:0]  sp_reg = 3'h0;
  logic        tog_reg = 1'b0;
  initial begin
    foreach (dm[i]) dm[i] = 8'(i * 29 + 3);
    foreach (stk[i]) stk[i] = 12'h000;
  end
  // Forward the write in flight so back-to-back ops see fresh data
  assign mem_operand = (dm_we_reg && dm_waddr_reg == instr_addr) ? dm_wdata_reg : dm[instr_addr];
  assign stack_top   = stk[sp_reg - 3'h1];
  // Outside a fetch the bus toggles, never holding the last word
  assign pm_rdata    = pm_req_reg ? {pm_addr_reg[10:4], pm_addr_reg[7:0] ^ 8'h5a} : {15{tog_reg}};
  always @(posedge clk) begin
    tog_reg <= !tog_reg;
    if (dm_we_reg) dm[dm_waddr_reg] <= dm_wdata_reg;
    if (rst) sp_reg <= 3'h0;
    else if (stack_push_reg) begin
      stk[sp_reg] <= stack_data_reg;
      sp_reg      <= sp_reg + 3'h1;
    end else if (stack_pop_reg) sp_reg <= sp_reg - 3'h1;
  end
endmodule : mit_mem_model

// ==== tb/mit_exec_test.sv ====
//==========================================================
// Purpose: Self-checking bench for the instruction executor
// Assumes: Memory model answers in the same cycle
// Notes:   Expected results are queued at issue, matched at retire
module mit_exec_test
  import mit_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {
    logic [7:0]  work, dm_addr, dm_data;
    logic [11:0] pc_val, push_data;
    logic [6:0]  table_hi;
    logic        carry, expiry, haltf, pdown, skip, ready, dm_we, pc_load, pc_free, push, pop, wdt_clr;
  } mit_note_t;
  logic        clk = 1'b0, rst = 1'b1, instr_valid = 1'b0, reg_we = 1'b0, reg_re = 1'b0, wdt_timeout = 1'b0;
  logic [5:0]  instr_op = 6'h00;
  logic [2:0]  instr_bit = 3'h0;
  logic [3:0]  reg_addr = 4'h0;
  logic [7:0]  instr_addr = 8'h00, instr_imm = 8'h00, table_ptr = 8'h00, reg_wdata = 8'h00;
  logic [11:0] instr_target = 12'h000, pc_now = 12'h000;
  logic [7:0]  mem_operand, work_reg, dm_waddr_reg, dm_wdata_reg, reg_rdata_reg;
  logic [11:0] stack_top, pc_value_reg, stack_data_reg, pm_addr_reg;
  logic [14:0] pm_rdata;
  logic [6:0]  table_high_reg;
  logic        ready_reg, retire_reg, carry_reg, expiry_flag_reg, halt_flag_reg, power_down_reg, dm_we_reg;
  logic        pc_load_reg, stack_push_reg, stack_pop_reg, skip_next_reg, pm_req_reg, wdt_clear_reg;
  int          fails = 0, comparisons = 0;
  mit_note_t   notes[$], cur;
  logic [7:0]  rd_q[$], sh_mem [256], sh_work = 8'h00, lfsr_reg = 8'h57;
  logic [11:0] sh_stk[$];
  logic [6:0]  sh_table_hi = 7'h00;
  logic        sh_carry = 1'b0, sh_exp = 1'b0, sh_haltf = 1'b0, sh_pdown = 1'b0, long_seen = 1'b0, re_seen = 1'b0;
  mit_op_t     sh_prev = OP_IDLE;

  mit_exec mit_exec_i (
    .clk, .rst, .instr_valid, .instr_op, .instr_addr, .instr_bit, .instr_imm, .instr_target, .mem_operand,
    .pc_now, .stack_top, .table_ptr, .pm_rdata, .wdt_timeout, .reg_addr, .reg_wdata, .reg_we, .reg_re,
    .ready_reg, .retire_reg, .work_reg, .carry_reg, .expiry_flag_reg, .halt_flag_reg, .power_down_reg,
    .dm_we_reg, .dm_waddr_reg, .dm_wdata_reg, .pc_load_reg, .pc_value_reg, .stack_push_reg, .stack_data_reg,
    .stack_pop_reg, .skip_next_reg, .pm_req_reg, .pm_addr_reg, .table_high_reg, .wdt_clear_reg, .reg_rdata_reg
  );
  mit_mem_model mit_mem_model_i (
    .clk, .rst, .instr_addr, .dm_we_reg, .dm_waddr_reg, .dm_wdata_reg, .stack_push_reg, .stack_data_reg,
    .stack_pop_reg, .pm_req_reg, .pm_addr_reg, .mem_operand, .stack_top, .pm_rdata
  );

  always #5 clk = ~clk;

  //==========================================================
  // Helpers
  function automatic logic [7:0] rnd();
    lfsr_reg = {lfsr_reg[6:0], lfsr_reg[7] ^ lfsr_reg[5] ^ lfsr_reg[4] ^ lfsr_reg[3]};
    return lfsr_reg;
  endfunction : rnd
  // Random address kept off the program counter byte
  function automatic logic [7:0] raddr();
    logic [7:0] a;
    a = rnd();
    return (a == PC_LOW_ADDR) ? 8'h40 : a;
  endfunction : raddr
  function automatic logic [7:0] status();
    return {4'h0, sh_pdown, sh_haltf, sh_exp, sh_carry};
  endfunction : status
  task automatic tally_and_finish();
    if (fails == 0 && comparisons > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : tally_and_finish
  task automatic chk(input string what, input logic [15:0] e, input logic [15:0] g);
    comparisons++;
    if (g !== e) begin
      fails++;
      $display("Error %s expected %h seen %h", what, e, g);
    end
  endtask : chk

  //==========================================================
  // Drivers: each assigns its signals only at its start, except tick_timeout, which pulses wdt_timeout midway
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    reg_we <= 1'b1;
    reg_re <= 1'b0;
    instr_valid <= 1'b0;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
  endtask : wr
  task automatic rd(input logic [3:0] a, input logic [7:0] e);
    reg_re <= 1'b1;
    reg_we <= 1'b0;
    instr_valid <= 1'b0;
    reg_addr <= a;
    rd_q.push_back(e);
    @(posedge clk);
  endtask : rd
  task automatic settle(input int c);
    instr_valid <= 1'b0;
    reg_we <= 1'b0;
    reg_re <= 1'b0;
    repeat (c) @(posedge clk);
  endtask : settle
  task automatic tick_timeout();
    // Let pending results retire before the flag moves
    settle(2);
    wdt_timeout <= 1'b1;
    @(posedge clk);
    wdt_timeout <= 1'b0;
    repeat (2) @(posedge clk);
    {sh_exp, sh_pdown} = 2'b10;
  endtask : tick_timeout
  task automatic issue(input mit_op_t op, input logic [7:0] a, input logic [2:0] b = 3'h0);
    mit_note_t   n;
    logic [7:0]  m, r, imm, tp;
    logic [11:0] pc, tgt;
    logic [14:0] w;
    int          k;
    imm = rnd();
    tp = rnd();
    pc = {4'(rnd()), rnd()};
    tgt = {4'(rnd()), rnd()};
    m = sh_mem[a];
    r = m;
    n = '0;
    case (op)
      OP_ROT_R, OP_ROT_R_W:       r = {m[0], m[7:1]};
      OP_ROT_RC, OP_ROT_RC_W:     {r, sh_carry} = {sh_carry, m};
      OP_ROT_L, OP_ROT_L_W:       r = {m[6:0], m[7]};
      OP_ROT_LC, OP_ROT_LC_W:     {sh_carry, r} = {m, sh_carry};
      OP_COPY_W2M:                r = sh_work;
      OP_BIT_CLR:                 r[b] = 1'b0;
      OP_BIT_SET:                 r[b] = 1'b1;
      OP_INC_SKIP, OP_INC_SKIP_W: r = m + 8'h01;
      OP_DEC_SKIP, OP_DEC_SKIP_W: r = m - 8'h01;
      OP_BYTE_CLR:                r = 8'h00;
      OP_BYTE_SET:                r = 8'hff;
      OP_SWAP, OP_SWAP_W:         r = {m[3:0], m[7:4]};
      OP_COPY_I2W, OP_SUB_EXIT_IMM: sh_work = imm;
      default: ;
    endcase
    if (op inside {OP_ROT_R_W, OP_ROT_RC_W, OP_ROT_L_W, OP_ROT_LC_W, OP_COPY_M2W, OP_SKIP_ZERO_W,
                   OP_INC_SKIP_W, OP_DEC_SKIP_W, OP_SWAP_W}) sh_work = r;
    case (op)
      OP_SKIP_ZERO, OP_SKIP_ZERO_W: n.skip = (m == 8'h00);
      OP_SKIP_BIT_CLR:              n.skip = !m[b];
      OP_SKIP_BIT_SET:              n.skip = m[b];
      OP_INC_SKIP, OP_INC_SKIP_W, OP_DEC_SKIP, OP_DEC_SKIP_W: n.skip = (r == 8'h00);
      OP_JUMP:                      {n.pc_load, n.pc_val} = {1'b1, tgt};
      OP_CALL: begin
        {n.pc_load, n.pc_val, n.push, n.push_data} = {1'b1, tgt, 1'b1, pc + 12'h001};
        sh_stk.push_back(pc + 12'h001);
      end
      OP_SUB_EXIT, OP_SUB_EXIT_IMM, OP_INT_EXIT: {n.pop, n.pc_load, n.pc_val} = {2'b11, sh_stk.pop_back()};
      OP_TBL_CUR, OP_TBL_LAST: begin
        w = {(op == OP_TBL_CUR) ? pc[10:8] : LAST_PAGE[2:0], tp[7:4], tp ^ 8'h5a};
        r = w[7:0];
        sh_table_hi = w[14:8];
      end
      OP_WDT_CLR:                   n.wdt_clr = 1'b1;
      OP_WDT_PRE1, OP_WDT_PRE2:     n.wdt_clr = sh_prev inside {OP_WDT_PRE1, OP_WDT_PRE2} && sh_prev != op;
      OP_HALT:                      {n.wdt_clr, sh_pdown} = 2'b11;
      default: ;
    endcase
    if (n.wdt_clr) {sh_exp, sh_haltf} = {1'b0, op == OP_HALT};
    n.dm_we = op inside {OP_ROT_R, OP_ROT_RC, OP_ROT_L, OP_ROT_LC, OP_COPY_W2M, OP_BIT_CLR, OP_BIT_SET,
                         OP_INC_SKIP, OP_DEC_SKIP, OP_BYTE_CLR, OP_BYTE_SET, OP_SWAP, OP_TBL_CUR, OP_TBL_LAST};
    if (n.dm_we) sh_mem[a] = r;
    {n.dm_addr, n.dm_data, n.pc_free} = {a, r, n.dm_we && a == PC_LOW_ADDR};
    if (n.pc_free) {n.pc_load, n.pc_val} = {1'b1, pc[11:8], r};
    n.ready = !(n.pop || n.pc_load || n.skip || sh_pdown || n.pc_free);
    {n.work, n.carry, n.expiry, n.haltf, n.pdown, n.table_hi} = {sh_work, sh_carry, sh_exp, sh_haltf, sh_pdown,
                                                                 sh_table_hi};
    // A clear consumes the pair, so the next pre-clear starts afresh
    sh_prev = n.wdt_clr ? OP_IDLE : op;
    notes.push_back(n);
    instr_valid <= 1'b1;
    reg_we <= 1'b0;
    reg_re <= 1'b0;
    instr_op <= op;
    instr_addr <= a;
    instr_bit <= b;
    instr_imm <= imm;
    instr_target <= tgt;
    pc_now <= pc;
    table_ptr <= tp;
    for (k = 0; k < 20; k++) begin
      @(posedge clk);
      if (ready_reg === 1'b1) break;
    end
    if (k == 20) begin
      fails++;
      tally_and_finish();
    end
  endtask : issue

  //==========================================================
  // Result watcher
  always @(posedge clk) begin
    if (long_seen) chk("ready_reg", 16'(1'b1), 16'(ready_reg));
    long_seen = 1'b0;
    if (re_seen) chk("reg_rdata_reg", 16'(rd_q.pop_front()), 16'(reg_rdata_reg));
    re_seen = reg_re;
    if (!rst && retire_reg === 1'b1 && notes.size() == 0) chk("retire_reg", 16'(1'b0), 16'(1'b1));
    else if (!rst && retire_reg === 1'b1) begin
      cur = notes.pop_front();
      long_seen = !cur.ready && !cur.pdown;
      chk("work_reg", 16'(cur.work), 16'(work_reg));
      chk("carry_reg", 16'(cur.carry), 16'(carry_reg));
      chk("expiry_flag_reg", 16'(cur.expiry), 16'(expiry_flag_reg));
      chk("halt_flag_reg", 16'(cur.haltf), 16'(halt_flag_reg));
      chk("power_down_reg", 16'(cur.pdown), 16'(power_down_reg));
      chk("skip_next_reg", 16'(cur.skip), 16'(skip_next_reg));
      chk("ready_reg", 16'(cur.ready), 16'(ready_reg));
      chk("dm_we_reg", 16'(cur.dm_we), 16'(dm_we_reg));
      if (cur.dm_we) chk("dm_write", {cur.dm_addr, cur.dm_data}, {dm_waddr_reg, dm_wdata_reg});
      chk("pc_load_reg", 16'(cur.pc_load), 16'(pc_load_reg));
      if (cur.pc_load) chk("pc_value_reg", 16'(cur.pc_val), 16'(pc_value_reg));
      chk("stack_push_reg", 16'(cur.push), 16'(stack_push_reg));
      if (cur.push) chk("stack_data_reg", 16'(cur.push_data), 16'(stack_data_reg));
      chk("stack_pop_reg", 16'(cur.pop), 16'(stack_pop_reg));
      chk("wdt_clear_reg", 16'(cur.wdt_clr), 16'(wdt_clear_reg));
      chk("table_high_reg", 16'(cur.table_hi), 16'(table_high_reg));
    end
  end

  //==========================================================
  // Main sequence
  initial begin
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    foreach (sh_mem[i]) sh_mem[i] = mit_mem_model_i.dm[i];
    @(posedge clk);
    wr(REG_CTRL, 8'h06);
    sh_carry = 1'b1;
    for (int i = 0; i < 111; i++) begin
      if (!((i % 37) inside {[14:18], [27:28], [31:33], 36})) issue(mit_op_t'(i % 37), raddr(), 3'(rnd()));
    end
    issue(OP_BYTE_CLR, 8'h20);
    issue(OP_SKIP_ZERO, 8'h20);
    issue(OP_SKIP_ZERO_W, 8'h20);
    issue(OP_BYTE_SET, 8'h21);
    issue(OP_INC_SKIP, 8'h21);
    issue(OP_INC_SKIP_W, 8'h21);
    issue(OP_COPY_W2M, 8'h22);
    issue(OP_DEC_SKIP, 8'h22);
    issue(OP_ROT_LC_W, 8'h21);
    issue(OP_SWAP, 8'h23);
    for (int k = 0; k < 4; k++) begin
      issue(k[0] ? OP_BIT_SET : OP_BIT_CLR, 8'h23, {3{k[1]}});
      issue(OP_SKIP_BIT_CLR, 8'h23, {3{k[1]}});
      issue(OP_SKIP_BIT_SET, 8'h23, {3{k[1]}});
    end
    issue(OP_JUMP, 8'h00);
    repeat (3) issue(OP_CALL, 8'h00);
    issue(OP_SUB_EXIT, 8'h00);
    issue(OP_SUB_EXIT_IMM, 8'h00);
    issue(OP_INT_EXIT, 8'h00);
    issue(OP_COPY_W2M, PC_LOW_ADDR);
    issue(OP_TBL_CUR, raddr());
    issue(OP_TBL_LAST, raddr());
    tick_timeout();
    issue(OP_HALT, 8'h00);
    settle(3);
    rd(REG_STATUS, status());
    wr(REG_CTRL, 8'h01);
    sh_pdown = 1'b0;
    tick_timeout();
    issue(OP_WDT_PRE1, 8'h00);
    issue(OP_IDLE, 8'h00);
    issue(OP_WDT_PRE2, 8'h00);
    issue(OP_WDT_PRE2, 8'h00);
    issue(OP_WDT_PRE1, 8'h00);
    tick_timeout();
    issue(OP_WDT_CLR, 8'h00);
    issue(OP_HALT, 8'h00);
    settle(2);
    tick_timeout();
    rd(REG_WORK, sh_work);
    rd(4'h9, 8'h00);
    wr(REG_STATUS, 8'hff);
    rd(REG_STATUS, status());
    settle(4);
    for (int k = 0; k < 50 && notes.size() != 0; k++) @(posedge clk);
    if (notes.size() != 0 || rd_q.size() != 0) fails++;
    tally_and_finish();
  end
endmodule : mit_exec_test
